// [odsw_pkg.sv]
// Shared constants and carriers for the octal converter serial write port
package odsw_pkg;

  // ----------------------------------------------------------------
  // Frame geometry
  // ----------------------------------------------------------------
  localparam int FRAME_BITS = 32;
  localparam int CHANNELS = 8;
  localparam int CODE_BITS = 16;
  localparam logic [4:0] CNT_RST = 5'h00;
  localparam logic [4:0] CNT_LAST = 5'h1F;

  // ----------------------------------------------------------------
  // Command codes and fields
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_WRITE_UPD = 4'h3;
  localparam logic [3:0] CMD_POWER = 4'h4;
  localparam logic [3:0] CMD_REF = 4'h8;
  localparam logic [3:0] ADDR_ALL = 4'hF;
  localparam int PD_ON_BIT = 8;
  localparam int REF_ON_BIT = 0;

  // ----------------------------------------------------------------
  // Power-on values
  // ----------------------------------------------------------------
  localparam logic [15:0] CODE_ZERO = 16'h0000;
  localparam logic [15:0] CODE_MID = 16'h8000;
  localparam logic [7:0] LOADED_RST = 8'h00;
  localparam logic [7:0] PD_RST = 8'h00;
  localparam logic REF_RST = 1'b0;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] prefix;
    logic [3:0] cmd;
    logic [3:0] addr;
    logic [15:0] data;
    logic [3:0] feature;
  } odsw_word_s;

  typedef struct packed {
    logic [7:0] loaded;
    logic [7:0] pd;
    logic ref_on;
  } odsw_stat_s;

endpackage

// [odsw_buf2.sv]
// Small valid/ready buffer between the frame shifter and the output logic
`timescale 1ns/1ps
`default_nettype none
module odsw_buf2 #(
  parameter int W = 32,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0] mem_r [DEPTH];
  logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic push, pop;

  // ----------------------------------------------------------------
  // Pointers and fill count
  // ----------------------------------------------------------------
  always_comb begin
    in_ready = (cnt_r != CW'(DEPTH));
    out_valid = (cnt_r != '0);
    out_data = mem_r[rp_r];
    push = in_valid & in_ready;
    pop = out_valid & out_ready;
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r;
    if (push) begin
      wp_nxt = (wp_r == PW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
    end
    if (pop) begin
      rp_nxt = (rp_r == PW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  property p_buf_count;
    @(posedge clk) disable iff (rst)
    (push && !pop) |=> (cnt_r == $past(cnt_r) + 1'b1) && (cnt_r <= CW'(DEPTH));
  endproperty
  a_buf_count: assert property (p_buf_count) else $error("buffer count wrong after push");

endmodule
`default_nettype wire

// [odsw_port.sv]
// Serial write port of an eight-channel converter: framing, buffer, command apply
//
// Contract
// - Strobe falling arms the shift register; data taken on later falling clock edges.
// - One data bit per falling clock edge into a 32-bit shift register.
// - Frame acts on the outputs only after its 32nd falling clock edge.
// - Strobe rising before the 32nd edge aborts the frame without effect.
// - After power-on outputs hold zero or midscale until a code is written.
// - Internal reference starts off; only a command turns it on.
// - Channel power-down is commanded over this same serial port only.
`timescale 1ns/1ps
`default_nettype none
module odsw_port #(
  parameter logic RESET_MIDSCALE = 1'b0,
  parameter int BUF_DEPTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial pins
  input wire logic frame_n,
  input wire logic sclk,
  input wire logic sdin,
  // Converter core handshake
  input wire logic apply_ready,
  // Channel outputs
  output logic [odsw_pkg::CHANNELS-1:0][odsw_pkg::CODE_BITS-1:0] ch_code,
  output odsw_pkg::odsw_stat_s stat,
  // Frame events
  output logic frame_abort,
  output logic word_drop
);
  localparam logic [15:0] CODE_RST = RESET_MIDSCALE ? odsw_pkg::CODE_MID : odsw_pkg::CODE_ZERO;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic fn_m_r, fn_s_r, fn_d_r;
  logic ck_m_r, ck_s_r, ck_d_r;
  logic dn_m_r, dn_s_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      fn_m_r <= 1'b1;
      fn_s_r <= 1'b1;
      fn_d_r <= 1'b1;
      ck_m_r <= 1'b0;
      ck_s_r <= 1'b0;
      ck_d_r <= 1'b0;
      dn_m_r <= 1'b0;
      dn_s_r <= 1'b0;
    end else begin
      fn_m_r <= frame_n;
      fn_s_r <= fn_m_r;
      fn_d_r <= fn_s_r;
      ck_m_r <= sclk;
      ck_s_r <= ck_m_r;
      ck_d_r <= ck_s_r;
      dn_m_r <= sdin;
      dn_s_r <= dn_m_r;
    end
  end

  // ----------------------------------------------------------------
  // Frame shifter
  // ----------------------------------------------------------------
  logic fn_fall, fn_rise, ck_fall, buf_in_ready;
  logic act_r, act_nxt, done_r, done_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic [odsw_pkg::FRAME_BITS-1:0] shift_r, shift_nxt, push_w_r, push_w_nxt;
  logic push_v_r, push_v_nxt, abort_nxt, drop_nxt;

  always_comb begin
    fn_fall = fn_d_r & ~fn_s_r;
    fn_rise = ~fn_d_r & fn_s_r;
    ck_fall = ck_d_r & ~ck_s_r;
    act_nxt = act_r;
    done_nxt = done_r;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    push_w_nxt = push_w_r;
    push_v_nxt = push_v_r & ~buf_in_ready;
    abort_nxt = 1'b0;
    drop_nxt = 1'b0;
    if (fn_fall) begin
      act_nxt = 1'b1;
      done_nxt = 1'b0;
      cnt_nxt = odsw_pkg::CNT_RST;
    end else if (act_r && !fn_s_r && ck_fall && !done_r) begin
      shift_nxt = {shift_r[odsw_pkg::FRAME_BITS-2:0], dn_s_r};
      if (cnt_r == odsw_pkg::CNT_LAST) begin
        done_nxt = 1'b1;
        cnt_nxt = odsw_pkg::CNT_RST;
        push_v_nxt = 1'b1;
        push_w_nxt = shift_nxt;
        drop_nxt = push_v_r & ~buf_in_ready;
      end else begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end else if (fn_rise) begin
      act_nxt = 1'b0;
      abort_nxt = act_r & ~done_r;
      done_nxt = 1'b0;
      cnt_nxt = odsw_pkg::CNT_RST;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      act_r <= 1'b0;
      done_r <= 1'b0;
      cnt_r <= odsw_pkg::CNT_RST;
      shift_r <= '0;
      push_w_r <= '0;
      push_v_r <= 1'b0;
      frame_abort <= 1'b0;
      word_drop <= 1'b0;
    end else begin
      act_r <= act_nxt;
      done_r <= done_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      push_w_r <= push_w_nxt;
      push_v_r <= push_v_nxt;
      frame_abort <= abort_nxt;
      word_drop <= drop_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Word buffer
  // ----------------------------------------------------------------
  logic buf_v;
  logic [odsw_pkg::FRAME_BITS-1:0] buf_w;

  odsw_buf2 #(
    .W(odsw_pkg::FRAME_BITS),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .clk(clk),
    .rst(rst),
    .in_valid(push_v_r),
    .in_data(push_w_r),
    .in_ready(buf_in_ready),
    .out_valid(buf_v),
    .out_ready(apply_ready),
    .out_data(buf_w)
  );

  // ----------------------------------------------------------------
  // Command apply
  // ----------------------------------------------------------------
  odsw_pkg::odsw_word_s w;
  logic take;
  logic [odsw_pkg::CHANNELS-1:0][odsw_pkg::CODE_BITS-1:0] code_nxt;
  odsw_pkg::odsw_stat_s stat_nxt;

  always_comb begin
    w = odsw_pkg::odsw_word_s'(buf_w);
    take = buf_v & apply_ready;
    code_nxt = ch_code;
    stat_nxt = stat;
    if (take) begin
      case (w.cmd)
        odsw_pkg::CMD_WRITE_UPD: begin
          for (int i = 0; i < odsw_pkg::CHANNELS; i++) begin
            if (w.addr == odsw_pkg::ADDR_ALL || w.addr == 4'(i)) begin
              code_nxt[i] = w.data;
              stat_nxt.loaded[i] = 1'b1;
            end
          end
        end
        odsw_pkg::CMD_POWER: begin
          for (int i = 0; i < odsw_pkg::CHANNELS; i++) begin
            if (w.data[i]) begin
              stat_nxt.pd[i] = w.data[odsw_pkg::PD_ON_BIT];
            end
          end
        end
        odsw_pkg::CMD_REF: begin
          stat_nxt.ref_on = w.data[odsw_pkg::REF_ON_BIT];
        end
        default: begin
          stat_nxt = stat;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ch_code <= {odsw_pkg::CHANNELS{CODE_RST}};
      stat.loaded <= odsw_pkg::LOADED_RST;
      stat.pd <= odsw_pkg::PD_RST;
      stat.ref_on <= odsw_pkg::REF_RST;
    end else begin
      ch_code <= code_nxt;
      stat <= stat_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_arm;
    @(posedge clk) disable iff (rst)
    (fn_d_r && !fn_s_r) |=> act_r && (cnt_r == odsw_pkg::CNT_RST) && !done_r;
  endproperty
  a_arm: assert property (p_arm) else $error("strobe fall did not arm shifter");

  property p_shift;
    @(posedge clk) disable iff (rst)
    (act_r && !fn_s_r && ck_fall && !done_r && !fn_fall) |=>
      (shift_r[0] == $past(dn_s_r)) && (shift_r[31:1] == $past(shift_r[30:0]));
  endproperty
  a_shift: assert property (p_shift) else $error("bit not shifted on clock fall");

  property p_push_at_32;
    @(posedge clk) disable iff (rst)
    (ck_fall && act_r && !fn_s_r && !done_r && !fn_fall && cnt_r == odsw_pkg::CNT_LAST)
      |=> push_v_r && done_r && (push_w_r == shift_r);
  endproperty
  a_push_at_32: assert property (p_push_at_32) else $error("word not pushed at edge 32");

  property p_push_cause;
    @(posedge clk) disable iff (rst)
    $rose(push_v_r) |-> $past(cnt_r) == odsw_pkg::CNT_LAST && $past(ck_fall);
  endproperty
  a_push_cause: assert property (p_push_cause) else $error("word pushed before edge 32");

  property p_abort;
    @(posedge clk) disable iff (rst)
    (fn_rise && act_r && !done_r) |=>
      frame_abort && !act_r && !$rose(push_v_r) ##1 !$rose(push_v_r);
  endproperty
  a_abort: assert property (p_abort) else $error("short frame not discarded");

  property p_por;
    @(posedge clk)
    $fell(rst) |-> (ch_code == {odsw_pkg::CHANNELS{CODE_RST}}) && (stat.loaded == 8'h00)
      && (stat.pd == 8'h00) && !stat.ref_on;
  endproperty
  a_por: assert property (p_por) else $error("power-on output state wrong");

  property p_ref;
    @(posedge clk) disable iff (rst)
    $rose(stat.ref_on) |-> $past(take) && ($past(w.cmd) == odsw_pkg::CMD_REF);
  endproperty
  a_ref: assert property (p_ref) else $error("reference turned on without command");

  property p_pd;
    @(posedge clk) disable iff (rst)
    (take && w.cmd == odsw_pkg::CMD_POWER && w.data[odsw_pkg::PD_ON_BIT])
      |=> ((stat.pd & $past(w.data[7:0])) == $past(w.data[7:0]));
  endproperty
  a_pd: assert property (p_pd) else $error("power-down command not applied");

endmodule
`default_nettype wire

// [odsw_host.sv]
// Behavioural host that sends frames over the serial write pins
`timescale 1ns/1ps
`default_nettype none
module odsw_host (
  // Serial pins
  output logic frame_n,
  output logic sclk,
  output logic sdin
);
  initial begin
    frame_n = 1'b1;
    sclk = 1'b0;
    sdin = 1'b0;
  end

  // ----------------------------------------------------------------
  // Frame sender: n bits of w, first bit first, 48 ns clock period
  // ----------------------------------------------------------------
  task automatic send(input logic [31:0] w, input int n);
    frame_n <= 1'b0;
    #24;
    for (int i = 0; i < n; i++) begin
      sclk <= 1'b1;
      sdin <= w[31-i];
      #24;
      sclk <= 1'b0;
      #24;
    end
    frame_n <= 1'b1;
    sdin <= ~sdin;
    #40;
  endtask
endmodule
`default_nettype wire

// [tb_odsw_port.sv]
// Self-checking bench for the serial write port with a scoreboard queue
`timescale 1ns/1ps
`default_nettype none
module tb_odsw_port;
  typedef struct packed {
    logic [1:0] kind;
    logic [7:0][15:0] code;
    odsw_pkg::odsw_stat_s st;
  } odsw_note_s;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic apply_ready = 1'b1;
  wire logic frame_n;
  wire logic sclk;
  wire logic sdin;
  logic [7:0][15:0] ch_code;
  odsw_pkg::odsw_stat_s stat;
  logic frame_abort;
  logic word_drop;
  logic [7:0][15:0] mid_code;
  odsw_pkg::odsw_stat_s mid_stat;
  logic [1:0] kind_seen;
  logic [7:0][15:0] e_code;
  odsw_pkg::odsw_stat_s e_st;
  odsw_note_s q[$];
  odsw_note_s prev;
  logic [31:0] r = 32'h80E666F1;
  logic [31:0] sw[3];
  int failures = 0;
  int compares = 0;

  always #2.5 clk = ~clk;

  odsw_host i_host (.frame_n(frame_n), .sclk(sclk), .sdin(sdin));

  odsw_port #(.RESET_MIDSCALE(1'b0), .BUF_DEPTH(2)) i_dut (
    .clk(clk), .rst(rst), .frame_n(frame_n), .sclk(sclk), .sdin(sdin),
    .apply_ready(apply_ready), .ch_code(ch_code), .stat(stat),
    .frame_abort(frame_abort), .word_drop(word_drop)
  );

  // Midscale grade on the same pins, checked for its power-on codes
  odsw_port #(.RESET_MIDSCALE(1'b1), .BUF_DEPTH(2)) i_dut_mid (
    .clk(clk), .rst(rst), .frame_n(frame_n), .sclk(sclk), .sdin(sdin),
    .apply_ready(apply_ready), .ch_code(mid_code), .stat(mid_stat),
    .frame_abort(), .word_drop()
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  function automatic logic [31:0] mk(input logic [3:0] c, input logic [3:0] a,
                                     input logic [15:0] d);
    return {4'h0, c, a, d, 4'h0};
  endfunction

  task automatic check(input odsw_note_s seen, input odsw_note_s exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: port state %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    if (failures == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Expected effect of one whole word on the model state
  task automatic apply_word(input logic [31:0] w);
    if (w[27:24] == odsw_pkg::CMD_WRITE_UPD) begin
      for (int c = 0; c < 8; c++) begin
        if (w[23:20] == odsw_pkg::ADDR_ALL || w[23:20] == 4'(c)) begin
          e_code[c] = w[19:4];
          e_st.loaded[c] = 1'b1;
        end
      end
    end else if (w[27:24] == odsw_pkg::CMD_POWER) begin
      if (w[4+odsw_pkg::PD_ON_BIT])
        e_st.pd = e_st.pd | w[11:4];
      else
        e_st.pd = e_st.pd & ~w[11:4];
    end else if (w[27:24] == odsw_pkg::CMD_REF) begin
      e_st.ref_on = w[4+odsw_pkg::REF_ON_BIT];
    end
  endtask

  task automatic note(input logic [1:0] k);
    q.push_back({k, e_code, e_st});
  endtask

  task automatic drain;
    for (int k = 0; k < 3000 && q.size() != 0; k++)
      @(posedge clk);
    if (q.size() != 0) begin
      failures++;
      $display("wrong value at %0t: expected port activity never came", $time);
      complete_run();
    end
  endtask

  task automatic go(input logic [31:0] w);
    apply_word(w);
    note(2'h0);
    i_host.send(w, 32);
    drain();
  endtask

  // ----------------------------------------------------------------
  // Watcher: every visible port event consumes the oldest note
  // ----------------------------------------------------------------
  always @(negedge clk) begin
    if (!rst) begin
      if (frame_abort === 1'b1 || word_drop === 1'b1 || {2'h0, ch_code, stat} !== prev) begin
        if (q.size() == 0) begin
          failures++;
          $display("wrong value at %0t: unexpected port activity", $time);
        end else begin
          kind_seen = frame_abort ? 2'h1 : (word_drop ? 2'h2 : 2'h0);
          check({kind_seen, ch_code, stat}, q.pop_front());
        end
      end
    end
    prev <= {2'h0, ch_code, stat};
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    e_code = {8{odsw_pkg::CODE_ZERO}};
    e_st = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    check({2'h0, ch_code, stat}, {2'h0, e_code, e_st});
    check({2'h0, mid_code, mid_stat}, {2'h0, {8{odsw_pkg::CODE_MID}}, e_st});
    for (int i = 0; i < 6; i++) begin
      r = xs(r);
      go(mk(odsw_pkg::CMD_WRITE_UPD, {1'b0, r[2:0]}, r[31:16]));
    end
    r = xs(r);
    go(mk(odsw_pkg::CMD_WRITE_UPD, odsw_pkg::ADDR_ALL, r[15:0]));
    check({2'h0, mid_code, mid_stat}, {2'h0, e_code, e_st});
    go(mk(odsw_pkg::CMD_REF, 4'h0, 16'h0001));
    go(mk(odsw_pkg::CMD_POWER, 4'h0, 16'h01A5));
    go(mk(odsw_pkg::CMD_POWER, 4'h0, 16'h0021));
    go(mk(odsw_pkg::CMD_REF, 4'h0, 16'h0000));
    i_host.send(mk(4'h7, 4'h1, 16'h1234), 32);
    foreach (sw[j]) begin
      note(2'h1);
      r = xs(r);
      i_host.send(mk(odsw_pkg::CMD_WRITE_UPD, 4'h2, r[15:0]), j == 0 ? 31 : 10 - 9 * j);
      drain();
    end
    // Stall the core: two words fill the buffer, the third waits to enter
    // Fourth word overwrites the waiting third one and flags the loss
    @(posedge clk);
    apply_ready <= 1'b0;
    foreach (sw[j]) begin
      r = xs(r);
      sw[j] = mk(odsw_pkg::CMD_WRITE_UPD, 4'(j + 4), r[31:16]);
      i_host.send(sw[j], 32);
    end
    note(2'h2);
    i_host.send(mk(odsw_pkg::CMD_WRITE_UPD, 4'h7, 16'hBEEF), 32);
    drain();
    for (int j = 0; j < 2; j++) begin
      apply_word(sw[j]);
      note(2'h0);
    end
    apply_word(mk(odsw_pkg::CMD_WRITE_UPD, 4'h7, 16'hBEEF));
    note(2'h0);
    @(posedge clk);
    apply_ready <= 1'b1;
    drain();
    repeat (20) @(posedge clk);
    complete_run();
  end
endmodule
`default_nettype wire
